// [logic/qhp_pkg.sv]
/*
 * Constants of the queue host data port: register offsets, banks, field
 * positions, reset values and the request sequencer states.
 * Assumes a 100 MHz single clock domain shared with the host bus logic.
 */
//
// Behaviour
// - With auto-advance set, each receive data read moves the receive pointer on.
// - Each advance equals the access size: one, two or four bytes.
// - With auto-advance clear, data accesses leave the pointer; host writes it.
// - Receive pointer is eleven bits, read/write, resets to zero, addresses data.
// - Release command reloads the pointer with the next frame start.
// - Low data register reads the receive queue and writes the transmit queue.
// - High data register carries the upper word with the same steering.
// - Data moves correctly at even, odd or doubleword aligned pointers.
// - Byte, word and doubleword data accesses may be mixed freely.
// - Data registers are two words on a 16-bit bus, one on 32-bit.
// - Link change interrupt enable is bit 15, reset zero.
// - Transmit interrupt enable is bit 14, reset zero.
// - Receive interrupt enable is bit 13, reset zero.
// - Receive overrun interrupt enable is bit 11, reset zero.
// - Transmit stopped interrupt enable is bit 9, reset zero.
// - Receive stopped interrupt enable is bit 8, reset zero.
// - Receive error frame interrupt enable is bit 7, reset zero.
// - Host writes release; device frees frame, clears bit; host waits for clear.
// - Interrupt output asserts when a flag and its enable are both set.
// - With transmit auto-advance, data writes advance the transmit pointer by size.
package qhp_pkg;

	// Banks and byte offsets within a bank.
	localparam logic [7:0] QHP_BANK_QUEUE = 8'h11;
	localparam logic [7:0] QHP_BANK_IRQ = 8'h12;
	localparam logic [3:0] QHP_OFS_IRQ_EN = 4'h0;
	localparam logic [3:0] QHP_OFS_RX_PTR = 4'h6;
	localparam logic [3:0] QHP_OFS_DATA_LO = 4'h8;
	localparam logic [3:0] QHP_OFS_DATA_HI = 4'hA;

	// Interrupt enable field positions.
	localparam int QHP_BIT_LINK_CHANGE_IE = 15;
	localparam int QHP_BIT_TRANSMIT_IE = 14;
	localparam int QHP_BIT_RECEIVE_IE = 13;
	localparam int QHP_BIT_RX_OVERRUN_IE = 11;
	localparam int QHP_BIT_TX_STOPPED_IE = 9;
	localparam int QHP_BIT_RX_STOPPED_IE = 8;
	localparam int QHP_BIT_RX_ERROR_IE = 7;
	localparam logic [15:0] QHP_IRQ_EN_MASK = 16'hEB80;
	localparam logic [15:0] QHP_IRQ_EN_RESET = 16'h0000;

	// Receive pointer register fields.
	localparam int QHP_BIT_RX_AUTO = 14;
	localparam int QHP_PTR_W = 11;
	localparam logic [10:0] QHP_PTR_RESET = 11'h000;
	localparam logic QHP_AUTO_RESET = 1'b0;

	// Request sequencer states.
	typedef enum logic {QHP_IDLE, QHP_RD_WAIT} qhp_state_e;

endpackage : qhp_pkg

// [logic/qhp_port.sv]
/*
 * Host data port of the queue manager: receive pointer with auto-advance,
 * the low and high data registers steering reads to the receive queue and
 * writes to the transmit queue, and the interrupt enable register.
 * Assumes the host bus strobes, receive buffer and flags are on i_clk, the
 * receive buffer answers four bytes from o_rxq_addr in the cycle o_rxq_rd
 * is high, and the release command and transmit pointer live next door.
 */
module qhp_port
	import qhp_pkg::*;
#(
	parameter bit BUS16 = 1'b0
)
(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [7:0] i_bank,
	input wire logic [3:0] i_addr,
	input wire logic [3:0] i_be,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [31:0] i_wdata,
	output logic [31:0] o_rdata,
	output logic o_rvalid,
	output logic o_busy,
	output logic o_rxq_rd,
	output logic [10:0] o_rxq_addr,
	input wire logic [31:0] i_rxq_rdata,
	input wire logic i_rx_release,
	input wire logic [10:0] i_rx_next_start,
	output logic o_txq_wr,
	output logic [31:0] o_txq_wdata,
	output logic [2:0] o_txq_count,
	input wire logic i_tx_auto_advance,
	output logic o_tx_advance,
	output logic [2:0] o_tx_advance_by,
	input wire logic [15:0] i_irq_flags,
	output logic o_irq
);

	////////////////////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		qhp_state_e state;
		logic [15:0] irq_en;
		logic rx_auto;
		logic [10:0] rx_ptr;
		logic [31:0] rdata;
		logic rvalid;
		logic busy;
		logic [1:0] rd_lane;
		logic rd_hi16;
		logic rxq_rd;
		logic [10:0] rxq_addr;
		logic txq_wr;
		logic [31:0] txq_wdata;
		logic [2:0] txq_count;
		logic tx_adv;
		logic [2:0] tx_adv_by;
		logic irq;
	} qhp_state_s;

	qhp_state_s s;
	qhp_state_s next_s;

	// Lowest enabled byte lane of an access.
	function automatic logic [1:0] qhp_low_lane(input logic [3:0] be);
		logic [1:0] l;
		l = 2'h0;
		for (int k = 3; k >= 0; k--)
		begin
			if (be[k])
				l = k[1:0];
		end
		return l;
	endfunction : qhp_low_lane

	// Number of enabled byte lanes, which is the access size.
	function automatic logic [2:0] qhp_count(input logic [3:0] be);
		logic [2:0] c;
		c = 3'h0;
		for (int k = 0; k < 4; k++)
			c = c + {2'h0, be[k]};
		return c;
	endfunction : qhp_count

	////////////////////////////////////////////////////////////////////////////////////////
	// Access decode.

	logic hi16;
	logic [3:0] be32;
	logic [31:0] wd32;
	logic [1:0] low;
	logic [2:0] cnt;
	logic hit_data;
	logic hit_ptr;
	logic hit_ien;
	logic take_rd;
	logic take_wr;
	logic rd_data_take;
	logic wr_data_take;
	logic [10:0] ptr_plus;

	// A 16-bit host reaches the upper word at its own address; fold it into 32-bit lanes.
	assign hi16 = BUS16 & i_addr[1];
	assign be32 = hi16 ? {i_be[1:0], 2'h0} : i_be;
	assign wd32 = hi16 ? {i_wdata[15:0], 16'h0000} : i_wdata;
	assign low = qhp_low_lane(be32);
	assign cnt = qhp_count(be32);
	assign hit_data = (i_bank == QHP_BANK_QUEUE) &&
		(i_addr[3:2] == QHP_OFS_DATA_LO[3:2]);
	assign hit_ptr = (i_bank == QHP_BANK_QUEUE) && (i_addr[3:2] == QHP_OFS_RX_PTR[3:2]);
	assign hit_ien = (i_bank == QHP_BANK_IRQ) && (i_addr[3:2] == QHP_OFS_IRQ_EN[3:2]);
	assign take_rd = (s.state == QHP_IDLE) && i_rd && !i_wr;
	assign take_wr = (s.state == QHP_IDLE) && i_wr && !i_rd;
	assign rd_data_take = take_rd && hit_data;
	assign wr_data_take = take_wr && hit_data;
	assign ptr_plus = s.rx_ptr + {8'h00, cnt};

	////////////////////////////////////////////////////////////////////////////////////////
	// Next state.

	// Sequences each host request and updates registers and queue strobes.
	always_comb
	begin
		logic [15:0] ptr_val;
		logic [15:0] bmask;
		logic [31:0] place;
		ptr_val = {1'b0, s.rx_auto, 3'h0, s.rx_ptr};
		bmask = {{8{be32[3]}}, {8{be32[2]}}};
		place = 32'h0000_0000;
		next_s = s;
		next_s.rvalid = 1'b0;
		next_s.rxq_rd = 1'b0;
		next_s.txq_wr = 1'b0;
		next_s.tx_adv = 1'b0;
		next_s.irq = |(i_irq_flags & s.irq_en);
		case (s.state)
			QHP_IDLE:
			begin
				if (rd_data_take)
				begin
					next_s.rxq_rd = 1'b1;
					next_s.rxq_addr = s.rx_ptr;
					next_s.rd_lane = low;
					next_s.rd_hi16 = hi16;
					next_s.busy = 1'b1;
					next_s.state = QHP_RD_WAIT;
					if (s.rx_auto)
						next_s.rx_ptr = ptr_plus;
				end
				else if (take_rd)
				begin
					if (hit_ptr)
						place = {ptr_val, 16'h0000};
					else if (hit_ien)
						place = {16'h0000, s.irq_en};
					next_s.rdata = hi16 ? {16'h0000, place[31:16]} : place;
					next_s.rvalid = 1'b1;
				end
				if (wr_data_take)
				begin
					next_s.txq_wr = 1'b1;
					next_s.txq_wdata = wd32 >> {low, 3'h0};
					next_s.txq_count = cnt;
					next_s.tx_adv = i_tx_auto_advance;
					next_s.tx_adv_by = cnt;
				end
				else if (take_wr && hit_ptr)
				begin
					if (be32[2])
						next_s.rx_ptr[7:0] = wd32[23:16];
					if (be32[3])
					begin
						next_s.rx_ptr[10:8] = wd32[26:24];
						next_s.rx_auto = wd32[16 + QHP_BIT_RX_AUTO];
					end
				end
				else if (take_wr && hit_ien)
				begin
					bmask = {{8{be32[1]}}, {8{be32[0]}}};
					next_s.irq_en = ((s.irq_en & ~bmask) | (wd32[15:0] & bmask)) &
						QHP_IRQ_EN_MASK;
				end
			end
			QHP_RD_WAIT:
			begin
				place = i_rxq_rdata << {s.rd_lane, 3'h0};
				next_s.rdata = s.rd_hi16 ? {16'h0000, place[31:16]} : place;
				next_s.rvalid = 1'b1;
				next_s.busy = 1'b0;
				next_s.state = QHP_IDLE;
			end
			default:
			begin
				next_s.state = QHP_IDLE;
				next_s.busy = 1'b0;
			end
		endcase
		// A release outranks any advance in the same cycle.
		if (i_rx_release)
			next_s.rx_ptr = i_rx_next_start;
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// State register.

	// Registers the whole state; reset values are constants only.
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			s <= '0;
			s.state <= QHP_IDLE;
			s.irq_en <= QHP_IRQ_EN_RESET;
			s.rx_auto <= QHP_AUTO_RESET;
			s.rx_ptr <= QHP_PTR_RESET;
		end
		else
			s <= next_s;
	end

	// Outputs come straight from the state flops.
	assign o_rdata = s.rdata;
	assign o_rvalid = s.rvalid;
	assign o_busy = s.busy;
	assign o_rxq_rd = s.rxq_rd;
	assign o_rxq_addr = s.rxq_addr;
	assign o_txq_wr = s.txq_wr;
	assign o_txq_wdata = s.txq_wdata;
	assign o_txq_count = s.txq_count;
	assign o_tx_advance = s.tx_adv;
	assign o_tx_advance_by = s.tx_adv_by;
	assign o_irq = s.irq;

	////////////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking qhp_cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);

	a_auto_ptr_step: assert property (
		rd_data_take && s.rx_auto && !i_rx_release |=> s.rx_ptr == $past(ptr_plus))
		else $error("receive pointer did not advance by the access size");

	a_manual_ptr_hold: assert property (
		rd_data_take && !s.rx_auto && !i_rx_release |=> $stable(s.rx_ptr))
		else $error("receive pointer moved with auto-advance clear");

	a_release_reload: assert property (
		i_rx_release |=> s.rx_ptr == $past(i_rx_next_start))
		else $error("release did not reload the receive pointer");

	a_rx_read_path: assert property (
		rd_data_take |=> o_rxq_rd && o_rxq_addr == $past(s.rx_ptr) ##1 o_rvalid && !o_busy)
		else $error("data read did not fetch from the receive queue");

	a_tx_write_path: assert property (
		wr_data_take |=> o_txq_wr && o_txq_count == $past(cnt) && !o_rxq_rd)
		else $error("data write did not reach the transmit queue");

	a_tx_advance: assert property (
		wr_data_take && i_tx_auto_advance |=> o_tx_advance && o_tx_advance_by == $past(cnt))
		else $error("transmit advance missing or wrong size");

	a_enable_reserved: assert property (
		(s.irq_en & ~QHP_IRQ_EN_MASK) == 16'h0000)
		else $error("reserved enable bit set");

	a_link_irq_gate: assert property (
		i_irq_flags == 16'h8000 && !s.irq_en[QHP_BIT_LINK_CHANGE_IE] |=> !o_irq)
		else $error("link change interrupt passed while disabled");

	a_irq_follows: assert property (
		(i_irq_flags & s.irq_en) != 16'h0000 |=> o_irq)
		else $error("enabled flag did not raise the interrupt");

	a_write_keeps_ptr: assert property (
		wr_data_take && !i_rx_release |=> $stable(s.rx_ptr))
		else $error("data write moved the receive pointer");

	a_ptr_low_write: assert property (
		take_wr && hit_ptr && be32[2] && !i_rx_release |=> s.rx_ptr[7:0] == $past(wd32[23:16]))
		else $error("pointer low byte write was lost");

	a_ptr_high_write: assert property (
		take_wr && hit_ptr && be32[3] && !i_rx_release |=>
			s.rx_ptr[10:8] == $past(wd32[26:24]) && s.rx_auto == $past(wd32[16 + QHP_BIT_RX_AUTO]))
		else $error("pointer high byte or auto-advance write was lost");

	a_byte_lane_write: assert property (
		wr_data_take && cnt == 3'h1 |=> o_txq_wdata[7:0] == $past(wd32[{low, 3'h0} +: 8]))
		else $error("byte write took the wrong lane");

	a_read_lane_zero: assert property (
		s.state == QHP_RD_WAIT && s.rd_lane == 2'h0 && !s.rd_hi16 |=>
			o_rdata == $past(i_rxq_rdata))
		else $error("aligned read data mismatch");

	a_read_hi_word: assert property (
		s.state == QHP_RD_WAIT && s.rd_hi16 && s.rd_lane == 2'h2 |=>
			o_rdata == {16'h0000, $past(i_rxq_rdata[15:0])})
		else $error("upper data word not returned in the low half");

	a_enable_write: assert property (
		take_wr && hit_ien && be32[1:0] == 2'h3 |=>
			s.irq_en == ($past(wd32[15:0]) & QHP_IRQ_EN_MASK))
		else $error("enable register write mismatch");

	a_busy_single: assert property (
		o_busy |=> !o_busy)
		else $error("read wait lasted more than one cycle");

	a_busy_drops: assert property (
		o_busy |=> !o_txq_wr && !o_rxq_rd)
		else $error("request accepted while busy");

	a_irq_quiet: assert property (
		(i_irq_flags & s.irq_en) == 16'h0000 |=> !o_irq)
		else $error("interrupt raised with no enabled flag");

	a_tx_hold: assert property (
		!wr_data_take |=> !o_tx_advance)
		else $error("transmit advance without a data write");

endmodule : qhp_port

// [tb/qhp_rxq_model.sv]
/*
 * Receive buffer model facing the host data port.
 * Assumes fetches are one-cycle pulses with the byte address alongside.
 */
module qhp_rxq_model
	import qhp_pkg::*;
(
	input wire logic i_rd,
	input wire logic [10:0] i_addr,
	output logic [31:0] o_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] word;
	// Answers four bytes from the address; outside a fetch the word is inverted junk.
	always_comb
	begin
		for (int k = 0; k < 4; k++)
			word[8*k +: 8] = 8'(i_addr + 11'(k)) ^ 8'h5A;
		o_data = i_rd ? word : ~word;
	end
endmodule : qhp_rxq_model

// [tb/qhp_port_tb.sv]
/*
 * Self-checking bench of the host data port on both a 32-bit and a 16-bit host bus.
 * Assumes the receive buffer model answers in the cycle of each fetch.
 */
module qhp_port_tb
	import qhp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clk = 0, i_resetn = 0, rd = 0, wr = 0, rel = 0, tx_auto = 0;
	logic [7:0] bank = 0;
	logic [3:0] addr = 0, be = 0, m;
	logic [31:0] wdata = 0, rdata, rxq_rdata, txq_wdata, d, seed, msk, ex;
	logic [31:0] rdata16, rxq_rdata16, txq_wdata16, d16;
	logic [10:0] rxq_addr, ns = 0, fa, eptr, rxq_addr16;
	logic [15:0] flags = 0;
	logic [2:0] txq_count, adv_by, n, txq_count16;
	logic [1:0] lane;
	logic [4:0] sh;
	logic [3:0] qa;
	logic rvalid, busy, rxq_rd, txq_wr, adv, irq, eauto, rvalid16, rxq_rd16;
	int bad_count = 0, compares = 0;
	// Clock at 100 MHz.
	always #5 i_clk = ~i_clk;
	qhp_port i_qhp_port (.i_clk(i_clk), .i_resetn(i_resetn), .i_bank(bank), .i_addr(addr),
		.i_be(be), .i_rd(rd), .i_wr(wr), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
		.o_busy(busy), .o_rxq_rd(rxq_rd), .o_rxq_addr(rxq_addr), .i_rxq_rdata(rxq_rdata),
		.i_rx_release(rel), .i_rx_next_start(ns), .o_txq_wr(txq_wr), .o_txq_wdata(txq_wdata),
		.o_txq_count(txq_count), .i_tx_auto_advance(tx_auto), .o_tx_advance(adv),
		.o_tx_advance_by(adv_by), .i_irq_flags(flags), .o_irq(irq));
	qhp_rxq_model i_qhp_rxq_model (.i_rd(rxq_rd), .i_addr(rxq_addr), .o_data(rxq_rdata));
	// The same port on a 16-bit host bus, fed the same requests.
	qhp_port #(.BUS16(1'b1)) i_qhp_port16 (.i_clk(i_clk), .i_resetn(i_resetn), .i_bank(bank),
		.i_addr(addr), .i_be(be), .i_rd(rd), .i_wr(wr), .i_wdata(wdata), .o_rdata(rdata16),
		.o_rvalid(rvalid16), .o_busy(), .o_rxq_rd(rxq_rd16), .o_rxq_addr(rxq_addr16),
		.i_rxq_rdata(rxq_rdata16), .i_rx_release(rel), .i_rx_next_start(ns), .o_txq_wr(),
		.o_txq_wdata(txq_wdata16), .o_txq_count(txq_count16), .i_tx_auto_advance(tx_auto),
		.o_tx_advance(), .o_tx_advance_by(), .i_irq_flags(flags), .o_irq());
	qhp_rxq_model i_qhp_rxq_model16 (.i_rd(rxq_rd16), .i_addr(rxq_addr16), .o_data(rxq_rdata16));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [31:0] eword(input logic [10:0] a);
		return {8'(a + 11'h3), 8'(a + 11'h2), 8'(a + 11'h1), 8'(a)} ^ 32'h5A5A5A5A;
	endfunction : eword
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask : chk
	// Issues one read and waits a bounded time for its answer; no answer counts as a mismatch.
	task automatic rdr(input logic [7:0] b, input logic [3:0] a, input logic [3:0] e);
		logic got;
		got = 1'b0;
		@(negedge i_clk);
		{bank, addr, be, rd} = {b, a, e, 1'b1};
		@(negedge i_clk);
		rd = 0;
		for (int i = 0; i < 4 && !got; i++)
		begin
			if (rxq_rd === 1'b1)
			begin
				fa = rxq_addr;
				chk("busy", 1, 32'(busy));
			end
			if (rvalid16 === 1'b1)
				d16 = rdata16;
			if (rvalid === 1'b1)
			begin
				d = rdata;
				got = 1'b1;
			end
			else
				@(negedge i_clk);
		end
		chk("rvalid", 1, 32'(got));
	endtask : rdr
	task automatic wrr(input logic [7:0] b, input logic [3:0] a, input logic [3:0] e,
		input logic [31:0] v);
		@(negedge i_clk);
		{bank, addr, be, wdata, wr} = {b, a, e, v, 1'b1};
		@(negedge i_clk);
		wr = 0;
	endtask : wrr
	// Reads the pointer word as a dword lane pair and as a 16-bit word, and compares both.
	task automatic chk_ptr();
		rdr(8'h11, 4'h4, 4'hC);
		chk("pointer", 32'({1'b0, eauto, 3'b000, eptr}), {16'h0, d[31:16]});
		rdr(8'h11, 4'h6, 4'h3);
		chk("pointer16", 32'({1'b0, eauto, 3'b000, eptr}), {16'h0, d16[15:0]});
	endtask : chk_ptr
	task automatic final_report();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////////////////////
	// Cuts a hung run short.
	initial
	begin
		#100us;
		$display("BAD watchdog expected finish seen timeout");
		bad_count++;
		final_report();
	end
	// Main sequence: reset values, enables, interrupt, data traffic, release, second reset.
	initial
	begin
		seed = 32'hD2EAB466;
		{eptr, eauto} = 0;
		repeat (12) @(posedge i_clk);
		@(negedge i_clk);
		i_resetn = 1;
		rdr(8'h12, 4'h0, 4'h3);
		chk("irq_en", 0, {16'h0, d[15:0]});
		chk_ptr();
		wrr(8'h12, 4'h0, 4'h3, 32'hFFFF);
		rdr(8'h12, 4'h0, 4'h3);
		chk("irq_en", 32'hEB80, {16'h0, d[15:0]});
		rdr(8'h13, 4'h0, 4'hF);
		chk("unmapped", 0, d);
		for (int i = 0; i < 8; i++)
		begin
			seed = xs(seed);
			wrr(8'h12, 4'h0, 4'h3, {16'h0, seed[31:16]});
			flags = seed[15:0];
			@(negedge i_clk);
			chk("irq", 32'((seed[31:16] & seed[15:0] & 16'hEB80) != 0), 32'(irq));
		end
		// Corner case: a lone link change flag passes only with its own enable.
		wrr(8'h12, 4'h0, 4'h3, 32'h7FFF);
		flags = 16'h8000;
		@(negedge i_clk);
		chk("irq_link_off", 0, 32'(irq));
		wrr(8'h12, 4'h0, 4'h3, 32'h8000);
		@(negedge i_clk);
		chk("irq_link_on", 1, 32'(irq));
		// Random data traffic at every size and lane; word accesses also reach the high address.
		for (int i = 0; i < 40; i++)
		begin
			seed = xs(seed);
			n = seed[1:0] == 0 ? 3'd1 : seed[1:0] == 1 ? 3'd2 : 3'd4;
			lane = n == 3'd1 ? seed[17:16] : n == 3'd2 ? {seed[17], 1'b0} : 2'h0;
			sh = {lane, 3'h0};
			msk = n == 3'd1 ? 32'hFF : n == 3'd2 ? 32'hFFFF : 32'hFFFFFFFF;
			m = (n == 3'd1 ? 4'h1 : n == 3'd2 ? 4'h3 : 4'hF) << lane;
			qa = n == 3'd2 && lane == 2'h0 && seed[18] ? 4'hA : 4'h8;
			if (i % 5 == 0)
			begin
				{eauto, eptr} = {seed[2], seed[13:3]};
				wrr(8'h11, 4'h4, 4'hC, {1'b0, eauto, 3'b000, eptr, 16'h0});
			end
			if (seed[14])
			begin
				rdr(8'h11, qa, m);
				chk("fetch", 32'(eptr), 32'(fa));
				ex = (eword(eptr) << sh) & (msk << sh);
				chk("rdata", ex, d & (msk << sh));
				chk("rdata16", ex, d16 & (msk << sh));
				if (eauto)
					eptr = eptr + 11'(n);
			end
			else
			begin
				tx_auto = seed[15];
				wrr(8'h11, qa, m, seed);
				chk("txq_wr", 1, 32'(txq_wr));
				chk("txq_count", 32'(n), 32'(txq_count));
				chk("txq_count16", 32'(n), 32'(txq_count16));
				chk("txq_wdata", (seed >> sh) & msk, txq_wdata & msk);
				chk("txq_wdata16", (seed >> sh) & msk, txq_wdata16 & msk);
				chk("tx_adv", 32'(tx_auto), 32'(adv));
				if (tx_auto)
					chk("tx_adv_by", 32'(n), 32'(adv_by));
			end
			chk_ptr();
		end
		@(negedge i_clk);
		{rel, ns} = {1'b1, seed[26:16]};
		@(negedge i_clk);
		rel = 0;
		eptr = ns;
		chk_ptr();
		// Corner case: a release in the cycle of an advancing read must win.
		wrr(8'h11, 4'h4, 4'hC, 32'h4000_0000);
		@(negedge i_clk);
		{bank, addr, be, rd, rel, ns} = {8'h11, 4'h8, 4'hF, 1'b1, 1'b1, 11'h7FF ^ seed[26:16]};
		@(negedge i_clk);
		{rd, rel} = 2'b00;
		repeat (2) @(negedge i_clk);
		{eauto, eptr} = {1'b1, ns};
		chk_ptr();
		// A second reset in mid-run returns the registers to their reset values.
		@(negedge i_clk);
		i_resetn = 0;
		repeat (2) @(negedge i_clk);
		i_resetn = 1;
		{eauto, eptr} = 0;
		rdr(8'h12, 4'h0, 4'h3);
		chk("irq_en_rst", 0, {16'h0, d[15:0]});
		chk_ptr();
		final_report();
	end
endmodule : qhp_port_tb
